// ### design/flyback_pkg.sv
package flyback_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 40;
	localparam int WAKE_LATENCY_NS = 26600;
	localparam int WAKE_CYC = (WAKE_LATENCY_NS * CLK_MHZ + 999) / 1000;
	localparam int DEAD_TIME_PS = 236000;
	localparam int DEAD_CYC = (DEAD_TIME_PS * CLK_MHZ / 1000 + 999) / 1000;
	localparam int AUX_UNIT_PS = 15800;
	localparam int AUX_UNIT_NUM = AUX_UNIT_PS * CLK_MHZ / 1000;
	localparam int AUX_OFFSET_UNITS = 2;
	localparam int COEF_DIV = 65535;
	localparam int ZCD_REF_MV = 2340;
	localparam int LINE_HYST_V = 20;
	localparam int SEQ_PERIOD_CYC = 400;
	localparam int MAX_ON_CYC = 400;
	localparam int VALLEY_MAX = 6;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_ENTRY = 8'h00;
	localparam logic [7:0] OFF_EXIT = 8'h04;
	localparam logic [7:0] OFF_WAKE = 8'h08;
	localparam logic [7:0] OFF_PAUSE = 8'h0c;
	localparam logic [7:0] OFF_KNEE = 8'h10;
	localparam logic [7:0] OFF_PERIOD = 8'h14;
	localparam logic [7:0] OFF_BANDMIN = 8'h18;
	localparam logic [7:0] OFF_BANDMAX = 8'h1c;
	localparam logic [7:0] OFF_ZVSON = 8'h20;
	localparam logic [7:0] OFF_BULKSCALE = 8'h24;
	localparam logic [7:0] OFF_KZVS = 8'h28;
	localparam logic [7:0] OFF_KVOUT = 8'h2c;
	localparam logic [7:0] OFF_ZVSDLY = 8'h30;
	localparam logic [7:0] OFF_NEGMAG = 8'h34;
	localparam logic [7:0] OFF_SEQLEN = 8'h38;
	localparam logic [7:0] OFF_STATUS = 8'h3c;

	// ==========================================================
	// Reset values and fixed peak settings
	localparam logic [11:0] RST_ENTRY = 12'h0c8;
	localparam logic [11:0] RST_EXIT = 12'h3e8;
	localparam logic [11:0] RST_WAKE = 12'h190;
	localparam logic [11:0] RST_PAUSE = 12'h12c;
	localparam logic [11:0] RST_KNEE = 12'h640;
	localparam logic [15:0] RST_PERIOD = 16'h0190;
	localparam logic [15:0] RST_BANDMIN = 16'h0118;
	localparam logic [15:0] RST_BANDMAX = 16'h01f4;
	localparam logic [11:0] RST_ZVSON = 12'h0c8;
	localparam logic [15:0] RST_BULKSCALE = 16'h0100;
	localparam logic [15:0] RST_KZVS = 16'h1000;
	localparam logic [15:0] RST_KVOUT = 16'h1000;
	localparam logic [7:0] RST_ZVSDLY = 8'h04;
	localparam logic [7:0] RST_NEGMAG = 8'h00;
	localparam logic [3:0] RST_SEQLEN = 4'h6;
	localparam logic [11:0] SEQ_PEAK0 = 12'h080;
	localparam logic [11:0] SEQ_PEAK1 = 12'h0a0;
	localparam logic [11:0] SEQ_PEAK2 = 12'h0c0;
	localparam logic [11:0] SEQ_PEAK3 = 12'h0e0;
	localparam logic [11:0] EXIT_PEAK = 12'h200;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {M_RUN, M_BOFF, M_WAKE, M_BON} mode_t;
	typedef enum logic [2:0] {P_IDLE, P_DELAY, P_AUX, P_DEAD, P_MAIN} pulse_t;
endpackage

// ### design/flyback_burst_valley_zvs_control.sv
// How it works
// - Feedback below entry level: burst off, sleep.
// - Wake level starts pulses, pause level stops.
// - First burst pulse after fixed wake latency.
// - Burst pulse count fixed, not feedback driven.
// - Common burst period; peaks step, fourth repeats.
// - Above exit level, leave burst immediately.
// - After exit, fixed exit peak for next pulse.
// - Bulk setting disables aux; valley mode then.
// - Band maximum frequency hit: valley count plus one.
// - Keep stepping to sixth; equal band: frequency reduction.
// - Aux pulse, dead time, then main gate.
// - Dead time fixed at 10 cycles (236 ns rounded up, 250 ns).
// - Forced mode sets main period directly.
// - Aux starts configured delay after zero crossing.
// - Line threshold enables aux with 20 V hysteresis.
// - Zero crossing enables main gate pulse.
// - Aux width from bulk and zero-cross terms.
// - Bulk voltage derived from line-sense current.
// - Negative magnetization level is configurable.
// - Fixed frequency varies peak; next region varies period.
`timescale 1ns/10ps
`default_nettype none
module flyback_burst_valley_zvs_control #(
	parameter int SEQ_PERIOD = flyback_pkg::SEQ_PERIOD_CYC,
	parameter int MAX_ON = flyback_pkg::MAX_ON_CYC,
	parameter int VALLEYS = flyback_pkg::VALLEY_MAX
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [11:0] feedbackSample,
	input wire logic [11:0] zcdSample,
	input wire logic [11:0] lineSample,
	input wire logic zeroCrossPin,
	input wire logic peakTripPin,
	output logic mainGate,
	output logic zvsGate,
	output logic [11:0] peakLimit,
	output logic sleepMode
);
	// ==========================================================
	// Parameter checks
	if (SEQ_PERIOD < 1 || SEQ_PERIOD > 65535 || MAX_ON < 1 ||
		MAX_ON > 65535 || VALLEYS < 1 || VALLEYS > 7) begin : g_chk
		$error("flyback control parameter out of range");
	end

	localparam logic [15:0] SEQ_PER16 = 16'(SEQ_PERIOD);
	localparam logic [15:0] MAX_ON16 = 16'(MAX_ON);
	localparam logic [2:0] VMAX = 3'(VALLEYS);
	localparam logic [15:0] WAKE_LAST = 16'(flyback_pkg::WAKE_CYC - 1);
	localparam logic [15:0] DEAD_LAST = 16'(flyback_pkg::DEAD_CYC - 1);

	function automatic logic [11:0] seqPeak(input logic [3:0] idx);
		unique case (idx)
			4'h0: seqPeak = flyback_pkg::SEQ_PEAK0;
			4'h1: seqPeak = flyback_pkg::SEQ_PEAK1;
			4'h2: seqPeak = flyback_pkg::SEQ_PEAK2;
			default: seqPeak = flyback_pkg::SEQ_PEAK3;
		endcase
	endfunction

	// ==========================================================
	// Avalon slave: one wait state on every access
	logic ack_reg;
	logic [11:0] entry_reg, exit_reg, wake_reg, pause_reg, knee_reg;
	logic [11:0] zvsOn_reg;
	logic [15:0] period_reg, bandMin_reg, bandMax_reg;
	logic [15:0] bulkScale_reg, kZvs_reg, kVout_reg;
	logic [7:0] zvsDly_reg, negMag_reg;
	logic [3:0] seqLen_reg;
	logic [7:0] status;
	wire logic [7:0] regAddr = {address[7:2], 2'b00};
	wire logic wrHit = write & ack_reg;

	assign waitrequest = (read | write) & ~ack_reg;

	always_ff @(posedge clock) begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (read | write) & ~ack_reg;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			entry_reg <= flyback_pkg::RST_ENTRY;
			exit_reg <= flyback_pkg::RST_EXIT;
			wake_reg <= flyback_pkg::RST_WAKE;
			pause_reg <= flyback_pkg::RST_PAUSE;
			knee_reg <= flyback_pkg::RST_KNEE;
			period_reg <= flyback_pkg::RST_PERIOD;
			bandMin_reg <= flyback_pkg::RST_BANDMIN;
			bandMax_reg <= flyback_pkg::RST_BANDMAX;
			zvsOn_reg <= flyback_pkg::RST_ZVSON;
			bulkScale_reg <= flyback_pkg::RST_BULKSCALE;
			kZvs_reg <= flyback_pkg::RST_KZVS;
			kVout_reg <= flyback_pkg::RST_KVOUT;
			zvsDly_reg <= flyback_pkg::RST_ZVSDLY;
			negMag_reg <= flyback_pkg::RST_NEGMAG;
			seqLen_reg <= flyback_pkg::RST_SEQLEN;
		end else if (wrHit) begin
			case (regAddr)
				flyback_pkg::OFF_ENTRY: entry_reg <= writedata[11:0];
				flyback_pkg::OFF_EXIT: exit_reg <= writedata[11:0];
				flyback_pkg::OFF_WAKE: wake_reg <= writedata[11:0];
				flyback_pkg::OFF_PAUSE: pause_reg <= writedata[11:0];
				flyback_pkg::OFF_KNEE: knee_reg <= writedata[11:0];
				flyback_pkg::OFF_PERIOD: period_reg <= writedata[15:0];
				flyback_pkg::OFF_BANDMIN: bandMin_reg <= writedata[15:0];
				flyback_pkg::OFF_BANDMAX: bandMax_reg <= writedata[15:0];
				flyback_pkg::OFF_ZVSON: zvsOn_reg <= writedata[11:0];
				flyback_pkg::OFF_BULKSCALE: bulkScale_reg <= writedata[15:0];
				flyback_pkg::OFF_KZVS: kZvs_reg <= writedata[15:0];
				flyback_pkg::OFF_KVOUT: kVout_reg <= writedata[15:0];
				flyback_pkg::OFF_ZVSDLY: zvsDly_reg <= writedata[7:0];
				flyback_pkg::OFF_NEGMAG: negMag_reg <= writedata[7:0];
				flyback_pkg::OFF_SEQLEN: seqLen_reg <= writedata[3:0];
				default: ;
			endcase
		end
	end

	// Read data is captured in the wait cycle so it stands at the ack edge.
	always_ff @(posedge clock) begin
		if (sys_rst)
			readdata <= 32'h0000_0000;
		else if (read & ~ack_reg) begin
			case (regAddr)
				flyback_pkg::OFF_ENTRY: readdata <= {20'h0, entry_reg};
				flyback_pkg::OFF_EXIT: readdata <= {20'h0, exit_reg};
				flyback_pkg::OFF_WAKE: readdata <= {20'h0, wake_reg};
				flyback_pkg::OFF_PAUSE: readdata <= {20'h0, pause_reg};
				flyback_pkg::OFF_KNEE: readdata <= {20'h0, knee_reg};
				flyback_pkg::OFF_PERIOD: readdata <= {16'h0, period_reg};
				flyback_pkg::OFF_BANDMIN: readdata <= {16'h0, bandMin_reg};
				flyback_pkg::OFF_BANDMAX: readdata <= {16'h0, bandMax_reg};
				flyback_pkg::OFF_ZVSON: readdata <= {20'h0, zvsOn_reg};
				flyback_pkg::OFF_BULKSCALE: readdata <= {16'h0, bulkScale_reg};
				flyback_pkg::OFF_KZVS: readdata <= {16'h0, kZvs_reg};
				flyback_pkg::OFF_KVOUT: readdata <= {16'h0, kVout_reg};
				flyback_pkg::OFF_ZVSDLY: readdata <= {24'h0, zvsDly_reg};
				flyback_pkg::OFF_NEGMAG: readdata <= {24'h0, negMag_reg};
				flyback_pkg::OFF_SEQLEN: readdata <= {28'h0, seqLen_reg};
				flyback_pkg::OFF_STATUS: readdata <= {24'h0, status};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic zc1, zc2, zc3, tr1, tr2;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			{zc1, zc2, zc3, tr1, tr2} <= 5'h00;
		end else begin
			{zc1, zc2, zc3} <= {zeroCrossPin, zc1, zc2};
			{tr1, tr2} <= {peakTripPin, tr1};
		end
	end
	wire logic zcEdge = zc2 & ~zc3;

	// ==========================================================
	// Bulk voltage, aux enable and aux width, one stage registered
	logic [11:0] bulkV_reg;
	logic [15:0] auxCyc_reg;
	logic zvsActive_reg;
	logic [27:0] bulkProd;
	logic [27:0] t1Prod;
	logic [27:0] t2Prod;
	logic [11:0] zcdDiff;
	logic [13:0] units;
	logic [23:0] cycCalc;
	always_comb begin
		bulkProd = lineSample * bulkScale_reg;
		t1Prod = bulkV_reg * kZvs_reg;
		zcdDiff = (zcdSample < 12'(flyback_pkg::ZCD_REF_MV)) ?
			12'(flyback_pkg::ZCD_REF_MV) - zcdSample : 12'h000;
		t2Prod = zcdDiff * kVout_reg;
		units = 14'(t1Prod / flyback_pkg::COEF_DIV)
			+ 14'(flyback_pkg::AUX_OFFSET_UNITS)
			+ 14'(t2Prod / (flyback_pkg::COEF_DIV * 1000))
			+ 14'(negMag_reg);
		cycCalc = 24'((units * flyback_pkg::AUX_UNIT_NUM + 999) / 1000);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bulkV_reg <= 12'h000;
			auxCyc_reg <= 16'h0001;
		end else begin
			bulkV_reg <= bulkProd[19:8];
			auxCyc_reg <= (cycCalc == 24'h0) ? 16'h0001 : cycCalc[15:0];
		end
	end

	// Hysteresis keeps the aux path from chattering on line ripple.
	always_ff @(posedge clock) begin
		if (sys_rst)
			zvsActive_reg <= 1'b0;
		else if (bulkV_reg >= zvsOn_reg)
			zvsActive_reg <= 1'b1;
		else if (13'(bulkV_reg) + 13'(flyback_pkg::LINE_HYST_V)
			< 13'(zvsOn_reg))
			zvsActive_reg <= 1'b0;
	end

	// ==========================================================
	// Burst mode state machine
	flyback_pkg::mode_t mode_reg;
	flyback_pkg::pulse_t pulse_reg;
	logic [15:0] wakeCnt_reg, periodCnt_reg, pCnt_reg;
	logic [3:0] seqIdx_reg;
	logic exitPending_reg;
	logic [2:0] valleyCnt_reg, edgeCnt_reg;
	wire logic fbExit = feedbackSample > exit_reg;
	wire logic wakeDone = (mode_reg == flyback_pkg::M_WAKE) && !fbExit &&
		wakeCnt_reg == WAKE_LAST;
	wire logic freqReduce = bandMin_reg == bandMax_reg;
	// Widened so a crossing count saturated at 7 still meets the target.
	wire logic valleyHit = {1'b0, edgeCnt_reg} + 4'h1 >=
		{1'b0, valleyCnt_reg};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_reg <= flyback_pkg::M_RUN;
			wakeCnt_reg <= 16'h0000;
		end else begin
			wakeCnt_reg <= wakeCnt_reg + 16'h0001;
			unique case (mode_reg)
				flyback_pkg::M_RUN:
					if (feedbackSample < entry_reg)
						mode_reg <= flyback_pkg::M_BOFF;
				flyback_pkg::M_BOFF:
					if (fbExit)
						mode_reg <= flyback_pkg::M_RUN;
					else if (feedbackSample > wake_reg) begin
						mode_reg <= flyback_pkg::M_WAKE;
						wakeCnt_reg <= 16'h0000;
					end
				flyback_pkg::M_WAKE:
					if (fbExit)
						mode_reg <= flyback_pkg::M_RUN;
					else if (wakeDone)
						mode_reg <= flyback_pkg::M_BON;
				flyback_pkg::M_BON:
					if (fbExit)
						mode_reg <= flyback_pkg::M_RUN;
					else if (feedbackSample < pause_reg)
						mode_reg <= flyback_pkg::M_BOFF;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			sleepMode <= 1'b0;
		else
			sleepMode <= mode_reg == flyback_pkg::M_BOFF;
	end

	// ==========================================================
	// Pulse scheduling
	logic [15:0] target;
	logic goBurst, goRun, goZvs, goMain;
	always_comb begin
		// Below the knee the period stretches while the peak stays put.
		target = (feedbackSample >= knee_reg) ? period_reg :
			period_reg + 16'({knee_reg - feedbackSample, 2'b00});
		goBurst = pulse_reg == flyback_pkg::P_IDLE && (wakeDone ||
			(mode_reg == flyback_pkg::M_BON && !fbExit &&
			feedbackSample >= pause_reg && seqIdx_reg < seqLen_reg &&
			periodCnt_reg >= SEQ_PER16));
		goRun = pulse_reg == flyback_pkg::P_IDLE &&
			mode_reg == flyback_pkg::M_RUN &&
			periodCnt_reg >= target && zcEdge;
		goZvs = goRun && zvsActive_reg;
		goMain = goBurst || (goRun && !zvsActive_reg && (freqReduce ||
			valleyHit));
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pulse_reg <= flyback_pkg::P_IDLE;
			pCnt_reg <= 16'h0000;
			mainGate <= 1'b0;
			zvsGate <= 1'b0;
		end else begin
			pCnt_reg <= pCnt_reg + 16'h0001;
			unique case (pulse_reg)
				flyback_pkg::P_IDLE:
					if (goMain) begin
						pulse_reg <= flyback_pkg::P_MAIN;
						mainGate <= 1'b1;
						pCnt_reg <= 16'h0000;
					end else if (goZvs) begin
						pulse_reg <= flyback_pkg::P_DELAY;
						pCnt_reg <= 16'h0000;
					end
				flyback_pkg::P_DELAY:
					if (pCnt_reg >= 16'(zvsDly_reg)) begin
						pulse_reg <= flyback_pkg::P_AUX;
						zvsGate <= 1'b1;
						pCnt_reg <= 16'h0000;
					end
				flyback_pkg::P_AUX:
					if (pCnt_reg >= auxCyc_reg - 16'h0001) begin
						pulse_reg <= flyback_pkg::P_DEAD;
						zvsGate <= 1'b0;
						pCnt_reg <= 16'h0000;
					end
				flyback_pkg::P_DEAD:
					if (pCnt_reg == DEAD_LAST) begin
						pulse_reg <= flyback_pkg::P_MAIN;
						mainGate <= 1'b1;
						pCnt_reg <= 16'h0000;
					end
				flyback_pkg::P_MAIN:
					if (tr2 || pCnt_reg == MAX_ON16 - 16'h0001) begin
						pulse_reg <= flyback_pkg::P_IDLE;
						mainGate <= 1'b0;
					end
				default: begin
					pulse_reg <= flyback_pkg::P_IDLE;
					mainGate <= 1'b0;
					zvsGate <= 1'b0;
				end
			endcase
		end
	end

	wire logic mainStart = pulse_reg != flyback_pkg::P_MAIN &&
		(goMain || (pulse_reg == flyback_pkg::P_DEAD &&
		pCnt_reg == DEAD_LAST));

	// Period counter saturates so a long burst pause cannot wrap it.
	always_ff @(posedge clock) begin
		if (sys_rst)
			periodCnt_reg <= 16'h0000;
		else if (mainStart)
			periodCnt_reg <= 16'h0001;
		else if (periodCnt_reg != 16'hffff)
			periodCnt_reg <= periodCnt_reg + 16'h0001;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			edgeCnt_reg <= 3'h0;
		else if (mainGate)
			edgeCnt_reg <= 3'h0;
		else if (zcEdge && edgeCnt_reg != 3'h7)
			edgeCnt_reg <= edgeCnt_reg + 3'h1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			valleyCnt_reg <= 3'h1;
		else if (goMain && goRun && !freqReduce) begin
			if (periodCnt_reg < bandMin_reg && valleyCnt_reg < VMAX)
				valleyCnt_reg <= valleyCnt_reg + 3'h1;
			else if (periodCnt_reg > bandMax_reg && valleyCnt_reg > 3'h1)
				valleyCnt_reg <= valleyCnt_reg - 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			seqIdx_reg <= 4'h0;
		else if (mode_reg != flyback_pkg::M_WAKE &&
			mode_reg != flyback_pkg::M_BON)
			seqIdx_reg <= 4'h0;
		else if (goBurst && seqIdx_reg != 4'hf)
			seqIdx_reg <= seqIdx_reg + 4'h1;
	end

	// A new exit wins over the clear by a pulse in the same cycle.
	always_ff @(posedge clock) begin
		if (sys_rst)
			exitPending_reg <= 1'b0;
		else if (mode_reg != flyback_pkg::M_RUN && fbExit)
			exitPending_reg <= 1'b1;
		else if (mainStart)
			exitPending_reg <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			peakLimit <= 12'h000;
		else if (mainStart) begin
			if (exitPending_reg)
				peakLimit <= flyback_pkg::EXIT_PEAK;
			else if (mode_reg != flyback_pkg::M_RUN)
				peakLimit <= seqPeak(seqIdx_reg);
			else if (feedbackSample >= knee_reg)
				peakLimit <= feedbackSample;
			else
				peakLimit <= knee_reg;
		end
	end

	assign status = {freqReduce, zvsActive_reg, valleyCnt_reg,
		exitPending_reg, mode_reg};

	// ==========================================================
	// Assertions
	property p_entry;
		@(posedge clock) disable iff (sys_rst)
		mode_reg == flyback_pkg::M_RUN && feedbackSample < entry_reg
		|=> mode_reg == flyback_pkg::M_BOFF ##1 sleepMode;
	endproperty
	a_entry: assert property (p_entry) else $error("no burst entry");

	property p_wake;
		@(posedge clock) disable iff (sys_rst)
		mode_reg == flyback_pkg::M_BOFF && !fbExit &&
		feedbackSample > wake_reg |=> mode_reg == flyback_pkg::M_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_latency;
		@(posedge clock) disable iff (sys_rst)
		wakeDone |=> mainGate && mode_reg == flyback_pkg::M_BON;
	endproperty
	a_latency: assert property (p_latency) else $error("late pulse");

	property p_exit;
		@(posedge clock) disable iff (sys_rst)
		mode_reg != flyback_pkg::M_RUN && fbExit
		|=> mode_reg == flyback_pkg::M_RUN;
	endproperty
	a_exit: assert property (p_exit) else $error("slow exit");

	property p_exitPeak;
		@(posedge clock) disable iff (sys_rst)
		mainStart && exitPending_reg
		|=> peakLimit == flyback_pkg::EXIT_PEAK;
	endproperty
	a_exitPeak: assert property (p_exitPeak) else $error("exit peak");

	property p_seqPeak;
		@(posedge clock) disable iff (sys_rst)
		goBurst && !exitPending_reg && seqIdx_reg >= 4'h3
		|=> peakLimit == flyback_pkg::SEQ_PEAK3;
	endproperty
	a_seqPeak: assert property (p_seqPeak) else $error("seq peak");

	property p_dead;
		@(posedge clock) disable iff (sys_rst)
		$fell(zvsGate) |-> !mainGate [*8] ##1 !mainGate [*2]
		##1 $rose(mainGate);
	endproperty
	a_dead: assert property (p_dead) else $error("dead time");

	property p_noOverlap;
		@(posedge clock) disable iff (sys_rst)
		!(mainGate && zvsGate);
	endproperty
	a_noOverlap: assert property (p_noOverlap) else $error("overlap");

	property p_valley;
		@(posedge clock) disable iff (sys_rst)
		goMain && goRun && !freqReduce &&
		periodCnt_reg < bandMin_reg && valleyCnt_reg < VMAX
		|=> valleyCnt_reg == $past(valleyCnt_reg) + 3'h1;
	endproperty
	a_valley: assert property (p_valley) else $error("valley step");

	property p_auxDelay;
		@(posedge clock) disable iff (sys_rst)
		goZvs && zvsDly_reg == 8'h00 |=> ##1 $rose(zvsGate);
	endproperty
	a_auxDelay: assert property (p_auxDelay) else $error("aux delay");

	c_burst: cover property (@(posedge clock) disable iff (sys_rst)
		mode_reg == flyback_pkg::M_BOFF ##1 mode_reg == flyback_pkg::M_WAKE);
	c_bon: cover property (@(posedge clock) disable iff (sys_rst)
		wakeDone ##1 mainGate);
	c_zvs: cover property (@(posedge clock) disable iff (sys_rst)
		$fell(zvsGate) ##10 mainGate);
	c_step: cover property (@(posedge clock) disable iff (sys_rst)
		valleyCnt_reg == 3'h2);
endmodule
`default_nettype wire

// ### verif/flyback_stage.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Power stage stand-in.
module flyback_stage #(
	parameter int RING = 16,
	parameter int ON_CYC = 20
) (
	input wire logic clock,
	input wire logic mainGate,
	input wire logic zvsGate,
	input wire logic holdRing,
	output logic zeroCrossPin,
	output logic peakTripPin
);
	int onCnt = 0;
	int offCnt = 0;
	// The drain ringing is undamped here, so crossings keep coming while
	// both switches stay off; a real stage fades out after some periods.
	always @(posedge clock) begin
		onCnt <= mainGate ? onCnt + 1 : 0;
		offCnt <= (mainGate || zvsGate) ? 0 : offCnt + 1;
		peakTripPin <= mainGate && onCnt >= ON_CYC - 1;
		zeroCrossPin <= !holdRing && offCnt >= 4 && offCnt % RING >= RING / 2;
	end
	initial begin
		zeroCrossPin = 1'b0;
		peakTripPin = 1'b0;
	end
endmodule
`default_nettype wire

// ### verif/flyback_burst_valley_zvs_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module flyback_burst_valley_zvs_control_test;
	localparam int SEQP = 100;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic holdRing = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q;
	logic [31:0] seed = 32'h45;
	logic [11:0] feedbackSample = 12'h7d0;
	logic [11:0] zcdSample = 12'h924;
	logic [11:0] lineSample = 12'h000;
	logic [11:0] peakLimit;
	logic waitrequest, zeroCrossPin, peakTripPin, mainGate, zvsGate, sleepMode;
	logic [11:0] pk [5] = '{flyback_pkg::SEQ_PEAK0, flyback_pkg::SEQ_PEAK1,
		flyback_pkg::SEQ_PEAK2, flyback_pkg::SEQ_PEAK3, flyback_pkg::SEQ_PEAK3};
	int errors = 0;
	int samples_checked = 0;
	int n, w, d, k, lv, zv;

	always #12.5 clock = ~clock;

	flyback_burst_valley_zvs_control #(.SEQ_PERIOD(SEQP))
	i_flyback_burst_valley_zvs_control (.clock(clock), .sys_rst(sys_rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .feedbackSample(feedbackSample),
		.zcdSample(zcdSample), .lineSample(lineSample),
		.zeroCrossPin(zeroCrossPin), .peakTripPin(peakTripPin),
		.mainGate(mainGate), .zvsGate(zvsGate), .peakLimit(peakLimit),
		.sleepMode(sleepMode));
	flyback_stage i_flyback_stage (.clock(clock), .mainGate(mainGate),
		.zvsGate(zvsGate), .holdRing(holdRing),
		.zeroCrossPin(zeroCrossPin), .peakTripPin(peakTripPin));

	// ==========================================================
	// Helpers.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int auxExp(int b, int kz, int z, int kv, int nm);
		int u;
		u = b * kz / 65535 + 2 + (2340 - z) * kv / 65535000 + nm;
		return (u * flyback_pkg::AUX_UNIT_NUM + 999) / 1000;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic rd, input logic [7:0] a,
		input logic [31:0] dat);
		@(posedge clock);
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= dat;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic status;
		bus(1'b1, flyback_pkg::OFF_STATUS, 32'h0);
	endtask
	task automatic step;
		@(posedge clock);
		n++;
	endtask
	task automatic rise;
		n = 0;
		while (mainGate !== 1'b0 && n < 5000) step();
		while (mainGate !== 1'b1 && n < 5000) step();
		if (n >= 5000) begin
			errors++;
			$display("BAD mainGate expected 1 seen %b", mainGate);
		end
	endtask
	task automatic measZ;
		n = 0;
		while (zvsGate !== 1'b1 && n < 5000) step();
		if (n >= 5000) begin
			errors++;
			$display("BAD zvsGate expected 1 seen %b", zvsGate);
		end
		for (w = 0; zvsGate === 1'b1 && w < 100; w++) @(posedge clock);
		for (d = 0; mainGate !== 1'b1 && d < 100; d++) @(posedge clock);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		bus(1'b1, flyback_pkg::OFF_ENTRY, 32'h0);
		chk("entry", {20'h0, flyback_pkg::RST_ENTRY}, q);
		bus(1'b0, 8'h80, 32'h5a);
		bus(1'b1, 8'h80, 32'h0);
		chk("unmapped", 32'h0, q);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			bus(1'b0, flyback_pkg::OFF_ZVSDLY, {24'h0, seed[7:0]});
			bus(1'b1, flyback_pkg::OFF_ZVSDLY, 32'h0);
			chk("delay", {24'h0, seed[7:0]}, q);
		end
		$display("registers done");
		feedbackSample <= 12'h064;
		repeat (4) @(posedge clock);
		chk("sleep", 32'h1, {31'h0, sleepMode});
		status();
		chk("boff", 32'h1, {30'h0, q[1:0]});
		feedbackSample <= 12'h1f4;
		rise();
		w = flyback_pkg::WAKE_CYC;
		chk("latency", 32'h1, 32'(n >= w - 1 && n <= w + 4));
		chk("peak0", {20'h0, pk[0]}, {20'h0, peakLimit});
		for (k = 1; k < 5; k++) begin
			seed = xs(seed);
			feedbackSample <= 12'h1a0 + {3'h0, seed[8:0]};
			rise();
			chk("spacing", 32'(SEQP), 32'(n));
			chk("peak", {20'h0, pk[k]}, {20'h0, peakLimit});
		end
		feedbackSample <= 12'h0fa;
		repeat (4) @(posedge clock);
		status();
		chk("pause", 32'h1, {30'h0, q[1:0]});
		$display("burst done");
		feedbackSample <= 12'h1f4;
		rise();
		feedbackSample <= 12'h7d0;
		repeat (3) @(posedge clock);
		status();
		chk("exit", 32'h4, {29'h0, q[2:0]});
		rise();
		chk("exitpeak", {20'h0, flyback_pkg::EXIT_PEAK}, {20'h0, peakLimit});
		rise();
		chk("period", 32'h1, 32'(n >= 400 && n <= 424));
		chk("runpeak", 32'h7d0, {20'h0, peakLimit});
		holdRing <= 1'b1;
		repeat (100) @(posedge clock);
		n = 0;
		repeat (800) @(posedge clock) n += int'(mainGate === 1'b1);
		chk("nocross", 32'h0, 32'(n));
		holdRing <= 1'b0;
		rise();
		chk("cross", 32'h1, 32'(n < 40));
		$display("exit done");
		bus(1'b0, flyback_pkg::OFF_PERIOD, 32'h100);
		for (k = 0; k < 9; k++) rise();
		status();
		chk("valley", 32'h6, {29'h0, q[5:3]});
		bus(1'b0, flyback_pkg::OFF_BANDMAX, 32'h118);
		rise();
		rise();
		status();
		chk("freqred", 32'h1, {31'h0, q[7]});
		bus(1'b0, flyback_pkg::OFF_BANDMAX, 32'h1f4);
		bus(1'b0, flyback_pkg::OFF_PERIOD, 32'h190);
		$display("valley done");
		bus(1'b0, flyback_pkg::OFF_ZVSDLY, 32'h0);
		lineSample <= 12'd100;
		bus(1'b0, flyback_pkg::OFF_ZVSON, 32'd100);
		status();
		chk("zvson", 32'h1, {31'h0, q[6]});
		measZ();
		measZ();
		chk("auxw", 32'(auxExp(100, 4096, 2340, 4096, 0)), 32'(w));
		chk("dead", 32'(flyback_pkg::DEAD_CYC), 32'(d));
		bus(1'b0, flyback_pkg::OFF_NEGMAG, 32'h3);
		bus(1'b0, flyback_pkg::OFF_KVOUT, 32'hffff);
		for (k = 0; k < 3; k++) begin
			seed = xs(seed);
			lv = 100 + int'(seed[7:0]);
			zv = int'(seed[18:8]);
			lineSample <= 12'(lv);
			zcdSample <= 12'(zv);
			measZ();
			measZ();
			chk("auxr", 32'(auxExp(lv, 4096, zv, 65535, 3)), 32'(w));
		end
		lineSample <= 12'd85;
		repeat (3) @(posedge clock);
		status();
		chk("hyston", 32'h1, {31'h0, q[6]});
		lineSample <= 12'd79;
		repeat (300) @(posedge clock);
		status();
		chk("hystoff", 32'h0, {31'h0, q[6]});
		n = 0;
		repeat (600) @(posedge clock) n += int'(zvsGate === 1'b1);
		chk("noaux", 32'h0, 32'(n));
		$display("zvs done");
		wrap_up();
	end

	initial begin
		#1500000;
		errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
